/* design/ctt_fifo.sv */
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module ctt_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule // ctt_fifo

/* design/ctt_trail_term.sv */
// channel trail terminations, fault persistence and null adaptation source
`timescale 1ns/10ps
// Notes on behaviour
// - each source passes data, clock and supervision insert, and maps trail fail to server fail.
// - each sink sets trail fail action with server fail in and passes data, clock, frame start.
// - each sink sets its server fail cause with server fail in and shows it for management.
// - the server fail fault sets only after the cause held unbroken for 2.5 s, within 0.5 s.
// - the server fail fault clears only after the cause has stayed low for 10 s, within 0.5 s.
// - the null adaptation source passes application clock, supervision insert and server fail.
// - while idle insert is requested the null source sends the idle marker instead of data.
module ctt_trail_term #(
    parameter int              DW          = ctt_pkg::DATA_W,
    parameter int              NCH         = ctt_pkg::NUM_CH,
    parameter int              FIFO_DEPTH  = ctt_pkg::FIFO_DEPTH,
    parameter int              TICK_CYCLES = ctt_pkg::TICK_CYCLES,
    parameter int              SET_TICKS   = ctt_pkg::FAULT_SET_TICKS,
    parameter int              CLR_TICKS   = ctt_pkg::FAULT_CLR_TICKS,
    // idle marker word, value is arbitrary
    parameter logic [DW-1:0]   IDLE_WORD   = {DW{1'b0}}
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // source terminations, adapted side
    input  wire logic [NCH-1:0][DW-1:0] so_adapted_data,
    input  wire logic [NCH-1:0]      so_adapted_clock,
    input  wire logic [NCH-1:0]      so_supervision_insert,
    input  wire logic [NCH-1:0]      so_trail_fail_signal,
    // source terminations, connection side
    output logic [NCH-1:0][DW-1:0]   so_connection_data,
    output logic [NCH-1:0]           so_connection_clock,
    output logic [NCH-1:0]           so_supervision_out,
    output logic [NCH-1:0]           so_server_fail_out,
    // sink terminations, connection side
    input  wire logic [NCH-1:0][DW-1:0] sk_connection_data,
    input  wire logic [NCH-1:0]      sk_connection_clock,
    input  wire logic [NCH-1:0]      sk_frame_start_in,
    input  wire logic [NCH-1:0]      sk_supervision_insert,
    input  wire logic [NCH-1:0]      server_fail_in,
    // sink terminations, adapted side
    output logic [NCH-1:0][DW-1:0]   sk_adapted_data,
    output logic [NCH-1:0]           sk_adapted_clock,
    output logic [NCH-1:0]           adapted_frame_start,
    output logic [NCH-1:0]           sk_supervision_out,
    output logic [NCH-1:0]           trail_fail_signal,
    // sink management
    output logic [NCH-1:0]           server_fail_cause,
    output logic [NCH-1:0]           server_fail_fault,
    // null adaptation source, application side
    input  wire logic [DW-1:0]       app_data,
    input  wire logic                app_clock,
    input  wire logic                app_supervision_insert,
    input  wire logic                idle_insert_request,
    input  wire logic                app_server_fail,
    output logic                     app_ready,
    // null adaptation source, channel side
    output logic [DW-1:0]            adapted_data,
    output logic                     adapted_valid,
    input  wire logic                adapted_ready,
    output logic                     adapted_clock,
    output logic                     ap_supervision_out,
    output logic                     ap_trail_fail_out
);
    localparam int NCK    = 2 * NCH + 1;
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam int CW     = ctt_pkg::FAULT_CNT_W;

    // link clock synchronisers: sources, sinks, application
    logic [NCK-1:0] ck_meta_q, ck_s2_q, ck_s3_q, ck_rise;
    logic [NCK-1:0] ck_raw;

    assign ck_raw  = {app_clock, sk_connection_clock, so_adapted_clock};
    assign ck_rise = ck_s2_q & ~ck_s3_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_meta_q <= '0;
            ck_s2_q   <= '0;
            ck_s3_q   <= '0;
        end else begin
            ck_meta_q <= ck_raw;
            ck_s2_q   <= ck_meta_q;
            ck_s3_q   <= ck_s2_q;
        end
    end

    // time base tick
    logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
    logic              tick_q, tick_d;

    always_comb begin
        tick_d     = 1'b0;
        tick_cnt_d = tick_cnt_q + 1'b1;
        if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt_d = '0;
            tick_d     = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            tick_q     <= tick_d;
        end
    end

    // per channel source and sink terminations
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic [DW-1:0]     so_d_q, so_d_d, sk_d_q, sk_d_d;
        logic              so_ck_q, so_ck_d, so_sup_q, so_sup_d, so_ssf_q, so_ssf_d;
        logic              sk_ck_q, sk_ck_d, sk_fs_q, sk_fs_d, sk_sup_q, sk_sup_d;
        logic              tsf_q, tsf_d, cause_q, cause_d, fault_q, fault_d;
        ctt_pkg::ctt_flt_e st_q, st_d;
        logic [CW-1:0]     cnt_q, cnt_d;

        always_comb begin
            so_d_d   = so_d_q;
            sk_d_d   = sk_d_q;
            sk_fs_d  = sk_fs_q;
            if (ck_rise[c]) begin
                so_d_d = so_adapted_data[c];
            end
            if (ck_rise[NCH+c]) begin
                sk_d_d  = sk_connection_data[c];
                sk_fs_d = sk_frame_start_in[c];
            end
            so_ck_d  = ck_s3_q[c];
            so_sup_d = so_supervision_insert[c];
            so_ssf_d = so_trail_fail_signal[c];
            sk_ck_d  = ck_s3_q[NCH+c];
            sk_sup_d = sk_supervision_insert[c];
            tsf_d    = server_fail_in[c];
            cause_d  = server_fail_in[c];
        end

        // fault persistence
        always_comb begin
            st_d  = st_q;
            cnt_d = cnt_q;
            case (st_q)
                ctt_pkg::FLT_CLEAR: begin
                    if (cause_q) begin
                        st_d  = ctt_pkg::FLT_PEND_ON;
                        cnt_d = '0;
                    end
                end
                ctt_pkg::FLT_PEND_ON: begin
                    if (!cause_q) begin
                        st_d = ctt_pkg::FLT_CLEAR;
                    end else if (tick_q) begin
                        if (cnt_q == CW'(SET_TICKS - 1)) begin
                            st_d = ctt_pkg::FLT_ACTIVE;
                        end else begin
                            cnt_d = cnt_q + 1'b1;
                        end
                    end
                end
                ctt_pkg::FLT_ACTIVE: begin
                    if (!cause_q) begin
                        st_d  = ctt_pkg::FLT_PEND_OFF;
                        cnt_d = '0;
                    end
                end
                ctt_pkg::FLT_PEND_OFF: begin
                    if (cause_q) begin
                        st_d = ctt_pkg::FLT_ACTIVE;
                    end else if (tick_q) begin
                        if (cnt_q == CW'(CLR_TICKS - 1)) begin
                            st_d = ctt_pkg::FLT_CLEAR;
                        end else begin
                            cnt_d = cnt_q + 1'b1;
                        end
                    end
                end
                default: begin
                    st_d  = ctt_pkg::FLT_CLEAR;
                    cnt_d = '0;
                end
            endcase
            fault_d = (st_d == ctt_pkg::FLT_ACTIVE) || (st_d == ctt_pkg::FLT_PEND_OFF);
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                so_d_q   <= '0;
                sk_d_q   <= '0;
                so_ck_q  <= ctt_pkg::RST_LEVEL;
                so_sup_q <= ctt_pkg::RST_LEVEL;
                so_ssf_q <= ctt_pkg::RST_LEVEL;
                sk_ck_q  <= ctt_pkg::RST_LEVEL;
                sk_fs_q  <= ctt_pkg::RST_LEVEL;
                sk_sup_q <= ctt_pkg::RST_LEVEL;
                tsf_q    <= ctt_pkg::RST_LEVEL;
                cause_q  <= ctt_pkg::RST_LEVEL;
                fault_q  <= ctt_pkg::RST_LEVEL;
                st_q     <= ctt_pkg::FLT_CLEAR;
                cnt_q    <= '0;
            end else begin
                so_d_q   <= so_d_d;
                sk_d_q   <= sk_d_d;
                so_ck_q  <= so_ck_d;
                so_sup_q <= so_sup_d;
                so_ssf_q <= so_ssf_d;
                sk_ck_q  <= sk_ck_d;
                sk_fs_q  <= sk_fs_d;
                sk_sup_q <= sk_sup_d;
                tsf_q    <= tsf_d;
                cause_q  <= cause_d;
                fault_q  <= fault_d;
                st_q     <= st_d;
                cnt_q    <= cnt_d;
            end
        end

        assign so_connection_data[c]  = so_d_q;
        assign so_connection_clock[c] = so_ck_q;
        assign so_supervision_out[c]  = so_sup_q;
        assign so_server_fail_out[c]  = so_ssf_q;
        assign sk_adapted_data[c]     = sk_d_q;
        assign sk_adapted_clock[c]    = sk_ck_q;
        assign adapted_frame_start[c] = sk_fs_q;
        assign sk_supervision_out[c]  = sk_sup_q;
        assign trail_fail_signal[c]   = tsf_q;
        assign server_fail_cause[c]   = cause_q;
        assign server_fail_fault[c]   = fault_q;
    end

    // null adaptation source: words taken on each application clock rise while the fifo has room
    logic [DW-1:0] ap_word, fifo_data;
    logic          fifo_valid, fifo_in_ready, pop;
    logic [DW-1:0] ap_d_q, ap_d_d;
    logic          ap_v_q, ap_v_d, ap_ck_q, ap_ck_d, ap_sup_q, ap_sup_d;
    logic          ap_tsf_q, ap_tsf_d, ap_rdy_q, ap_rdy_d;

    assign ap_word = idle_insert_request ? IDLE_WORD : app_data;
    assign pop     = fifo_valid && (!ap_v_q || adapted_ready);

    ctt_fifo #(
        .WIDTH (DW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (ck_rise[NCK-1]),
        .in_ready  (fifo_in_ready),
        .in_data   (ap_word),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data)
    );

    always_comb begin
        ap_d_d = ap_d_q;
        ap_v_d = ap_v_q;
        if (pop) begin
            ap_d_d = fifo_data;
            ap_v_d = 1'b1;
        end else if (adapted_ready) begin
            ap_v_d = 1'b0;
        end
        ap_ck_d  = ck_s3_q[NCK-1];
        ap_sup_d = app_supervision_insert;
        ap_tsf_d = app_server_fail;
        ap_rdy_d = fifo_in_ready;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ap_d_q   <= '0;
            ap_v_q   <= 1'b0;
            ap_ck_q  <= ctt_pkg::RST_LEVEL;
            ap_sup_q <= ctt_pkg::RST_LEVEL;
            ap_tsf_q <= ctt_pkg::RST_LEVEL;
            ap_rdy_q <= 1'b0;
        end else begin
            ap_d_q   <= ap_d_d;
            ap_v_q   <= ap_v_d;
            ap_ck_q  <= ap_ck_d;
            ap_sup_q <= ap_sup_d;
            ap_tsf_q <= ap_tsf_d;
            ap_rdy_q <= ap_rdy_d;
        end
    end

    assign adapted_data       = ap_d_q;
    assign adapted_valid      = ap_v_q;
    assign adapted_clock      = ap_ck_q;
    assign ap_supervision_out = ap_sup_q;
    assign ap_trail_fail_out  = ap_tsf_q;
    assign app_ready          = ap_rdy_q;
endmodule // ctt_trail_term

/* pkg/ctt_pkg.sv */
// shared constants for the channel trail termination block
package ctt_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS  = 50;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_NS_PER_MS = 1000000;
    // fault persistence times
    localparam int FAULT_SET_MS    = 2500;
    localparam int FAULT_CLR_MS    = 10000;
    localparam int FAULT_SET_TICKS = FAULT_SET_MS * (TICK_NS_PER_MS / TICK_PERIOD_NS);
    localparam int FAULT_CLR_TICKS = FAULT_CLR_MS * (TICK_NS_PER_MS / TICK_PERIOD_NS);
    localparam int FAULT_CNT_W     = 14;
    // data path
    localparam int DATA_W     = 64;
    localparam int NUM_CH     = 4;
    localparam int FIFO_DEPTH = 4;
    // reset values
    localparam logic RST_LEVEL = 1'b0;
    // fault persistence states
    typedef enum logic [3:0] {
        FLT_CLEAR   = 4'h1,
        FLT_PEND_ON = 4'h2,
        FLT_ACTIVE  = 4'h4,
        FLT_PEND_OFF = 4'h8
    } ctt_flt_e;
endpackage

/* tb/ctt_far_end.sv */
// far side model: gated link clock and a stallable consumer of the adapted stream
`timescale 1ns/10ps
module ctt_far_end (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // link clock, runs only while requested
    input  wire logic                        run,
    output logic                             link_clk,
    // adapted stream
    input  wire logic [ctt_pkg::DATA_W-1:0]  data,
    input  wire logic                        valid,
    input  wire logic                        stall,
    output logic                             ready
);
    logic [ctt_pkg::DATA_W-1:0] got_q[$];
    // phase unrelated to clk; a started high phase is always finished
    initial begin
        link_clk = 1'b0;
        #37;
        forever begin
            #200;
            if (run || link_clk) link_clk = ~link_clk;
        end
    end
    assign ready = !stall;
    always @(posedge clk) begin
        if (rst_n && valid && ready) got_q.push_back(data);
    end
endmodule // ctt_far_end

/* tb/ctt_trail_term_sva.sv */
// assertion checker for the channel trail termination block
`timescale 1ns/10ps
module ctt_trail_term_sva #(
    parameter int NCH         = 4,
    parameter int DW          = 64,
    parameter int TICK_CYCLES = 4,
    parameter int SET_TICKS   = 5,
    parameter int CLR_TICKS   = 20
) (
    // clock and reset
    input wire logic           clk,
    input wire logic           rst_n,
    // sink and source levels
    input wire logic [NCH-1:0] server_fail_in,
    input wire logic [NCH-1:0] trail_fail_signal,
    input wire logic [NCH-1:0] server_fail_cause,
    input wire logic [NCH-1:0] server_fail_fault,
    input wire logic [NCH-1:0] so_trail_fail_signal,
    input wire logic [NCH-1:0] so_server_fail_out,
    input wire logic [NCH-1:0] so_supervision_insert,
    input wire logic [NCH-1:0] so_supervision_out,
    // null adaptation source
    input wire logic           app_server_fail,
    input wire logic           ap_trail_fail_out,
    input wire logic           adapted_valid,
    input wire logic           adapted_ready,
    input wire logic [DW-1:0]  adapted_data
);
    localparam int SET_MIN = (SET_TICKS - 1) * TICK_CYCLES;
    localparam int SET_MAX = (SET_TICKS + 1) * TICK_CYCLES + 3;
    localparam int CLR_MIN = (CLR_TICKS - 1) * TICK_CYCLES;
    localparam int CLR_MAX = (CLR_TICKS + 1) * TICK_CYCLES + 3;
    // cycles that the channel 0 cause has been high or low without a break
    logic [31:0] hi_q, lo_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_q <= 32'h0;
            lo_q <= 32'h0;
        end else begin
            hi_q <= server_fail_cause[0] ? hi_q + 32'h1 : 32'h0;
            lo_q <= server_fail_cause[0] ? 32'h0 : lo_q + 32'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence stall_s;
        adapted_valid && !adapted_ready;
    endsequence
    sequence held_s;
        adapted_valid && $stable(adapted_data);
    endsequence
    reset_clear_a: assert property ($rose(rst_n) |-> server_fail_fault == '0)
        else $error("fault not clear after reset");
    trail_follow_a: assert property ($past(rst_n) |->
        trail_fail_signal == $past(server_fail_in))
        else $error("trail fail does not follow server fail");
    cause_follow_a: assert property ($past(rst_n) |->
        server_fail_cause == $past(server_fail_in))
        else $error("fail cause does not follow server fail");
    src_fail_a: assert property ($past(rst_n) |->
        so_server_fail_out == $past(so_trail_fail_signal))
        else $error("source server fail wrong");
    src_sup_a: assert property ($past(rst_n) |->
        so_supervision_out == $past(so_supervision_insert))
        else $error("source supervision wrong");
    null_fail_a: assert property ($past(rst_n) |->
        ap_trail_fail_out == $past(app_server_fail))
        else $error("null source fail wrong");
    fault_early_a: assert property ($rose(server_fail_fault[0]) |-> hi_q >= SET_MIN)
        else $error("fault set too early");
    fault_late_a: assert property (hi_q > SET_MAX |-> server_fail_fault[0])
        else $error("fault set too late");
    clear_early_a: assert property ($fell(server_fail_fault[0]) |-> lo_q >= CLR_MIN)
        else $error("fault cleared too early");
    clear_late_a: assert property (lo_q > CLR_MAX |-> !server_fail_fault[0])
        else $error("fault cleared too late");
    stall_hold_a: assert property (stall_s |=> held_s)
        else $error("output word dropped while stalled");
endmodule // ctt_trail_term_sva
bind ctt_trail_term ctt_trail_term_sva #(.NCH(NCH), .DW(DW), .TICK_CYCLES(TICK_CYCLES),
    .SET_TICKS(SET_TICKS), .CLR_TICKS(CLR_TICKS)) u_ctt_trail_term_sva (
    .clk(clk), .rst_n(rst_n), .server_fail_in(server_fail_in),
    .trail_fail_signal(trail_fail_signal), .server_fail_cause(server_fail_cause),
    .server_fail_fault(server_fail_fault), .so_trail_fail_signal(so_trail_fail_signal),
    .so_server_fail_out(so_server_fail_out), .so_supervision_insert(so_supervision_insert),
    .so_supervision_out(so_supervision_out), .app_server_fail(app_server_fail),
    .ap_trail_fail_out(ap_trail_fail_out), .adapted_valid(adapted_valid),
    .adapted_ready(adapted_ready), .adapted_data(adapted_data));

/* tb/ctt_trail_term_test.sv */
// self-checking testbench for the channel trail termination block
`timescale 1ns/10ps
module ctt_trail_term_test;
    localparam int          NCH  = ctt_pkg::NUM_CH;
    localparam int          DW   = ctt_pkg::DATA_W;
    // idle marker, value is arbitrary
    localparam logic [63:0] IDLE = 64'hC3C3_0000_0000_3C3C;
    logic                   clk, rst_n, run, lclk, stall;
    logic [NCH-1:0][DW-1:0] so_d, so_cd, sk_d, sk_ad;
    logic [NCH-1:0]         so_tf, so_sup, so_cc, so_po, so_sf, sk_fs, sk_sup, sf_in;
    logic [NCH-1:0]         sk_ac, fs_o, sk_po, tf_o, cause, fault;
    logic [DW-1:0]          app_d, ad_d;
    logic                   app_sup, idle, app_sf, app_rdy, ad_v, ad_rdy, ad_ck, ap_po, ap_tf;
    int                     n_errors, n_compared, i;
    logic [DW-1:0]          exp_q[$];

    ctt_trail_term #(.TICK_CYCLES(4), .SET_TICKS(5), .CLR_TICKS(20), .IDLE_WORD(IDLE))
    u_ctt_trail_term (.clk(clk), .rst_n(rst_n), .so_adapted_data(so_d),
        .so_adapted_clock({NCH{lclk}}), .so_supervision_insert(so_sup),
        .so_trail_fail_signal(so_tf), .so_connection_data(so_cd), .so_connection_clock(so_cc),
        .so_supervision_out(so_po), .so_server_fail_out(so_sf), .sk_connection_data(sk_d),
        .sk_connection_clock({NCH{lclk}}), .sk_frame_start_in(sk_fs),
        .sk_supervision_insert(sk_sup), .server_fail_in(sf_in), .sk_adapted_data(sk_ad),
        .sk_adapted_clock(sk_ac), .adapted_frame_start(fs_o), .sk_supervision_out(sk_po),
        .trail_fail_signal(tf_o), .server_fail_cause(cause), .server_fail_fault(fault),
        .app_data(app_d), .app_clock(lclk), .app_supervision_insert(app_sup),
        .idle_insert_request(idle), .app_server_fail(app_sf), .app_ready(app_rdy),
        .adapted_data(ad_d), .adapted_valid(ad_v), .adapted_ready(ad_rdy),
        .adapted_clock(ad_ck), .ap_supervision_out(ap_po), .ap_trail_fail_out(ap_tf));
    ctt_far_end u_ctt_far_end (.clk(clk), .rst_n(rst_n), .run(run), .link_clk(lclk),
        .data(ad_d), .valid(ad_v), .stall(stall), .ready(ad_rdy));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk_flags(input string name, input logic [NCH-1:0] exp,
                             input logic [NCH-1:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_word(input string name, input logic [DW-1:0] exp,
                            input logic [DW-1:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one link clock pulse: every path takes one word, the null path only while its fifo has room
    task automatic pulse();
        run = 1'b1;
        for (int k = 0; k < 20 && !lclk; k++) tick(1);
        run = 1'b0;
        chk_flags("link clock", 4'h1, {3'h0, lclk});
        if (!lclk) begin
            end_of_test();
        end
        tick(5);
        chk_flags("clocks high", 4'hF, so_cc & sk_ac & {NCH{ad_ck}});
        tick(8);
        chk_flags("clocks low", 4'h0, so_cc | sk_ac | {NCH{ad_ck}});
    endtask
    initial begin
        rst_n = 1'b0;
        run = 1'b0;
        stall = 1'b0;
        n_errors = 0;
        n_compared = 0;
        so_d = '0;
        sk_d = '0;
        so_tf = '0;
        so_sup = '0;
        sk_fs = '0;
        sk_sup = '0;
        sf_in = '0;
        app_d = '0;
        app_sup = 1'b0;
        idle = 1'b0;
        app_sf = 1'b0;
        tick(10);
        rst_n = 1'b1;
        tick(1);
        chk_flags("fault after reset", 4'h0, fault | tf_o);
        for (i = 0; i < 2; i++) begin
            for (int c = 0; c < NCH; c++) begin
                so_d[c] = 64'h0123_4567_89AB_CDEF ^ {56'h0, 4'(c), 4'(i)};
                sk_d[c] = ~so_d[c];
            end
            sk_fs = 4'h5 ^ 4'(i * 15);
            so_sup = sk_fs;
            so_tf = ~sk_fs;
            sk_sup = ~sk_fs;
            app_sup = i[0];
            app_sf = ~i[0];
            pulse();
            for (int c = 0; c < NCH; c++) begin
                chk_word("source data", so_d[c], so_cd[c]);
                chk_word("sink data", sk_d[c], sk_ad[c]);
            end
            chk_flags("frame start", sk_fs, fs_o);
            chk_flags("source supervision", so_sup, so_po);
            chk_flags("source fail", so_tf, so_sf);
            chk_flags("sink supervision", sk_sup, sk_po);
            chk_flags("null levels", {2'h0, app_sup, app_sf}, {2'h0, ap_po, ap_tf});
        end
        sf_in = 4'h6;
        tick(1);
        chk_flags("trail fail", 4'h6, tf_o);
        chk_flags("fail cause", 4'h6, cause);
        sf_in = 4'hF;
        tick(12);
        sf_in = 4'h0;
        tick(2);
        chk_flags("fault after short cause", 4'h0, fault);
        sf_in = 4'hF;
        tick(30);
        chk_flags("fault set", 4'hF, fault);
        sf_in = 4'h0;
        tick(60);
        sf_in = 4'hF;
        tick(2);
        sf_in = 4'h0;
        tick(60);
        chk_flags("fault held", 4'hF, fault);
        tick(40);
        chk_flags("fault cleared", 4'h0, fault);
        sf_in = 4'hF;
        tick(30);
        sf_in = 4'h0;
        rst_n = 1'b0;
        tick(2);
        chk_flags("fault in reset", 4'h0, fault);
        rst_n = 1'b1;
        tick(2);
        u_ctt_far_end.got_q.delete();
        stall = 1'b1;
        for (i = 0; i < 6; i++) begin
            idle = i[0];
            app_d = 64'hFEDC_BA98_7654_3210 + 64'(i);
            if (i < 5) exp_q.push_back(idle ? IDLE : app_d);
            pulse();
        end
        chk_flags("buffer full", 4'h0, {3'h0, app_rdy});
        stall = 1'b0;
        for (i = 0; i < 50 && u_ctt_far_end.got_q.size() < 5; i++) tick(1);
        chk_flags("words drained", 4'h5, 4'(u_ctt_far_end.got_q.size()));
        for (i = 0; i < 5 && i < u_ctt_far_end.got_q.size(); i++) begin
            chk_word("null word", exp_q[i], u_ctt_far_end.got_q[i]);
        end
        tick(4);
        chk_flags("buffer empty", 4'h2, {2'h0, app_rdy, ad_v});
        end_of_test();
    end
endmodule // ctt_trail_term_test
